// ===== pkg/sdpt_map.svh
/*
  constants for the power-down and termination control block:
  field positions, widths and timing counts.
  assumes the includer compiles it once per unit; guarded anyway.
*/
`ifndef SDPT_MAP_SVH
`define SDPT_MAP_SVH

// clock rate in mhz
`define SDPT_CLK_MHZ 50
// entry guard interval in cycles (cke low to receivers off)
`define SDPT_CPDED_CYC 4'h1
// width of latency counters
`define SDPT_LAT_W 5
// width of the operation-in-flight countdown
`define SDPT_BUSY_W 8
// number of banks
`define SDPT_BANKS 8
// field positions of the captured mode bits
`define SDPT_MR0_A12 12
`define SDPT_MR1_A2 2
`define SDPT_MR1_A6 6
`define SDPT_MR1_A9 9
`define SDPT_MR2_A9 9
`define SDPT_MR2_A10 10
// minimum latency accepted for cwl + al - 2
`define SDPT_LAT_MIN 5'h0_1

`endif

// ===== pkg/sdpt_pkg.sv
/*
  types for the power-down and termination control block.
  assumes sdpt_map.svh is available on the include path.
*/
package sdpt_pkg;

  // power state, one-hot
  typedef enum logic [4:0] {
    SDPT_ST_ON     = 5'b0_0001, // cke high, normal operation
    SDPT_ST_SETTLE = 5'b0_0010, // cke low, finishing in-flight work
    SDPT_ST_APD    = 5'b0_0100, // active power-down
    SDPT_ST_PPD    = 5'b0_1000, // precharge power-down
    SDPT_ST_RST    = 5'b1_0000  // reset state
  } sdpt_state_t;

  // decoded command strobes sampled on a clock edge
  typedef struct packed {
    logic nop;   // nop or deselect
    logic act;   // activate
    logic pre;   // precharge single bank
    logic prea;  // precharge all
    logic wr;    // write
    logic rd;    // read
  } sdpt_cmd_t;

  // termination status seen by the pads
  typedef struct packed {
    logic       on;     // termination connected
    logic [2:0] nom;    // nominal resistance code
    logic [1:0] wrval;  // write resistance code
  } sdpt_term_t;

endpackage

// ===== core/sdpt_ctrl.sv
/*
  power-down entry/exit and synchronous on-die termination control.
  assumes cke, odt, reset_n and decoded commands are synchronous to clock,
  and that the controller keeps its own side of the protocol.
*/
`include "sdpt_map.svh"
module sdpt_ctrl #(
  parameter int BANKS = `SDPT_BANKS,
  parameter int BUSY_W = `SDPT_BUSY_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // memory pins, already decoded
  input wire logic cke,
  input wire logic odt,
  input wire logic reset_n,
  input wire sdpt_pkg::sdpt_cmd_t cmd,
  input wire logic [2:0] cmd_bank,
  // in-flight internal work (row, precharge, refresh) remaining cycles
  input wire logic [BUSY_W-1:0] op_busy_cyc,
  // mode register contents
  input wire logic [15:0] mr0,
  input wire logic [15:0] mr1,
  input wire logic [15:0] mr2,
  input wire logic [4:0] cwl,
  input wire logic [4:0] al,
  input wire logic dll_locked,
  input wire logic self_refresh,
  // read data drivers active
  input wire logic dq_driving,
  // status outputs
  output sdpt_pkg::sdpt_state_t pd_state,
  output logic in_buf_en,
  output logic cmd_rx_en,
  output logic dll_on,
  output logic sync_odt,
  output sdpt_pkg::sdpt_term_t term
);

  // power state and counters
  sdpt_pkg::sdpt_state_t state_ff, nxt_state;
  logic [BANKS-1:0] bank_open_ff, nxt_bank_open;
  logic [3:0] guard_ff, nxt_guard;
  // termination pipeline: one bit per latency stage
  logic [31:0] odt_pipe_ff, nxt_odt_pipe;
  logic term_on_ff, nxt_term_on;

  // termination enabled by any resistance bit
  logic [2:0] nom_bits;
  logic [1:0] wr_bits;
  logic mr_term_en;
  logic [4:0] lat;
  logic dll_run;
  assign nom_bits = {mr1[`SDPT_MR1_A9], mr1[`SDPT_MR1_A6], mr1[`SDPT_MR1_A2]};
  assign wr_bits = {mr2[`SDPT_MR2_A10], mr2[`SDPT_MR2_A9]};
  assign mr_term_en = (|nom_bits) | (|wr_bits);
  // latency; a setting below one is clamped so the pipeline stays causal
  assign lat = ((cwl + al) > 5'h0_2 + `SDPT_LAT_MIN) ? 5'(cwl + al - 5'h0_2) : `SDPT_LAT_MIN;

  // next power state, bank tracking and guard counter
  always_comb begin
    nxt_state = state_ff;
    nxt_bank_open = bank_open_ff;
    nxt_guard = guard_ff;
    // banks change only on commands received in the on state, and all clear while reset_n is low
    if (state_ff == sdpt_pkg::SDPT_ST_ON && cke) begin
      if (cmd.act) begin
        nxt_bank_open[cmd_bank] = 1'b1;
      end else if (cmd.pre) begin
        nxt_bank_open[cmd_bank] = 1'b0;
      end else if (cmd.prea) begin
        nxt_bank_open = '0;
      end
    end
    if (!reset_n) begin
      // reset wins over any power-down state
      nxt_state = sdpt_pkg::SDPT_ST_RST;
      nxt_bank_open = '0;
      nxt_guard = '0;
    end else begin
      unique case (state_ff)
        sdpt_pkg::SDPT_ST_RST: begin
          nxt_state = sdpt_pkg::SDPT_ST_ON;
        end
        sdpt_pkg::SDPT_ST_ON: begin
          if (!cke && cmd.nop && !self_refresh) begin
            nxt_state = sdpt_pkg::SDPT_ST_SETTLE;
            nxt_guard = `SDPT_CPDED_CYC;
          end
        end
        sdpt_pkg::SDPT_ST_SETTLE, sdpt_pkg::SDPT_ST_APD, sdpt_pkg::SDPT_ST_PPD: begin
          if (guard_ff != 4'h0) begin
            nxt_guard = guard_ff - 4'h1;
          end
          if (cke && cmd.nop) begin
            nxt_state = sdpt_pkg::SDPT_ST_ON;
          end else if (state_ff == sdpt_pkg::SDPT_ST_SETTLE && op_busy_cyc == '0) begin
            // in-flight work done: pick the type from open banks
            nxt_state = (|bank_open_ff) ? sdpt_pkg::SDPT_ST_APD : sdpt_pkg::SDPT_ST_PPD;
          end
        end
        default: nxt_state = sdpt_pkg::SDPT_ST_RST;
      endcase
    end
  end

  // register power state
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_ff <= sdpt_pkg::SDPT_ST_RST;
      bank_open_ff <= '0;
      guard_ff <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      bank_open_ff <= nxt_bank_open;
      guard_ff <= nxt_guard;
    end
  end

  // dll frozen only in slow-exit precharge power-down
  assign dll_run = !(state_ff == sdpt_pkg::SDPT_ST_PPD && !mr0[`SDPT_MR0_A12]);
  // synchronous timing needs a running, locked dll
  assign sync_odt = dll_run && dll_locked;

  // next termination state
  always_comb begin
    nxt_odt_pipe = {odt_pipe_ff[30:0], odt};
    nxt_term_on = 1'b0;
    if (self_refresh || !mr_term_en || state_ff == sdpt_pkg::SDPT_ST_RST) begin
      nxt_term_on = 1'b0;
    end else if (sync_odt) begin
      // the pin sampled lat edges ago decides; drivers hold it off
      nxt_term_on = odt_pipe_ff[lat - 5'h0_1] && !dq_driving;
    end else begin
      // frozen or unlocked dll: follow the pin without latency
      nxt_term_on = odt && !dq_driving;
    end
  end

  // register termination
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      odt_pipe_ff <= 32'h0000_0000;
      term_on_ff <= 1'b0;
    end else begin
      odt_pipe_ff <= nxt_odt_pipe;
      term_on_ff <= nxt_term_on;
    end
  end

  // outputs
  assign pd_state = state_ff;
  assign dll_on = dll_run;
  // input buffers on only in the on state, off in power-down and in reset
  assign in_buf_en = (state_ff == sdpt_pkg::SDPT_ST_ON);
  // command receivers survive the guard interval
  assign cmd_rx_en = in_buf_en || (state_ff != sdpt_pkg::SDPT_ST_RST && guard_ff != 4'h0);
  // one driver for the whole struct, so no tool sees several writers of one variable
  assign term = '{on: term_on_ff, nom: nom_bits, wrval: wr_bits};

  // power-down entry takes one edge
  pd_entry_a: assert property (@(posedge clock) disable iff (sys_rst)
    state_ff == sdpt_pkg::SDPT_ST_ON && !cke && cmd.nop && !self_refresh && reset_n
    |=> state_ff == sdpt_pkg::SDPT_ST_SETTLE)
    else $error("power-down not entered");
  pd_exit_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state_ff inside {sdpt_pkg::SDPT_ST_APD, sdpt_pkg::SDPT_ST_PPD}) && cke && cmd.nop && reset_n
    |=> state_ff == sdpt_pkg::SDPT_ST_ON)
    else $error("power-down not exited");
  pd_type_a: assert property (@(posedge clock) disable iff (sys_rst)
    state_ff == sdpt_pkg::SDPT_ST_PPD |-> bank_open_ff == '0)
    else $error("precharge power-down with open bank");
  settle_wait_a: assert property (@(posedge clock) disable iff (sys_rst)
    state_ff == sdpt_pkg::SDPT_ST_SETTLE && op_busy_cyc != '0 && !cke && reset_n
    |=> state_ff == sdpt_pkg::SDPT_ST_SETTLE)
    else $error("settled before work finished");
  reset_exit_a: assert property (@(posedge clock) disable iff (sys_rst)
    !reset_n |=> state_ff == sdpt_pkg::SDPT_ST_RST)
    else $error("reset did not force exit");
  dll_freeze_a: assert property (@(posedge clock) disable iff (sys_rst)
    state_ff == sdpt_pkg::SDPT_ST_APD |-> dll_on)
    else $error("dll off in active power-down");
  rx_guard_a: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(state_ff == sdpt_pkg::SDPT_ST_SETTLE) |-> cmd_rx_en && !in_buf_en)
    else $error("receivers off inside guard");
  term_off_a: assert property (@(posedge clock) disable iff (sys_rst)
    self_refresh || !mr_term_en |=> !term.on)
    else $error("termination on while disabled");
  term_lat_a: assert property (@(posedge clock) disable iff (sys_rst)
    sync_odt && mr_term_en && !self_refresh && !dq_driving && state_ff != sdpt_pkg::SDPT_ST_RST
    |=> term.on == $past(odt_pipe_ff[lat - 5'h0_1]))
    else $error("termination latency wrong");
  term_drive_a: assert property (@(posedge clock) disable iff (sys_rst)
    dq_driving |=> !term.on)
    else $error("terminating while driving");

  // main scenarios
  cov_apd_c: cover property (@(posedge clock) state_ff == sdpt_pkg::SDPT_ST_APD);
  cov_ppd_c: cover property (@(posedge clock) state_ff == sdpt_pkg::SDPT_ST_PPD && !dll_on);
  cov_term_c: cover property (@(posedge clock) $rose(term.on));
  cov_rst_c: cover property (@(posedge clock) $past(state_ff == sdpt_pkg::SDPT_ST_APD) && !reset_n);

endmodule

// ===== tb/sdpt_host.sv
/*
  memory controller model: drives cke, odt, reset_n and commands.
  assumes the bench calls its tasks; every change lands on a rising edge.
*/
module sdpt_host (
  // clock
  input wire logic clock,
  // controller pins
  output logic cke,
  output logic odt,
  output logic reset_n,
  output sdpt_pkg::sdpt_cmd_t cmd,
  output logic [2:0] cmd_bank
);
  timeunit 1ns;
  timeprecision 1ns;
  // nop stays on the bus by default, which covers the entry guard
  localparam sdpt_pkg::sdpt_cmd_t NOP = 6'h20;
  initial begin
    cke = 1'b1;
    odt = 1'b0;
    reset_n = 1'b1;
    cmd = NOP;
    cmd_bank = 3'h0;
  end
  // cke only moves while no burst is in flight
  task automatic set_cke(input logic v);
    @(posedge clock);
    cke <= v;
  endtask
  // odt not lowered around reads; the bench leaves it high while dq_driving is set
  task automatic set_odt(input logic v);
    @(posedge clock);
    odt <= v;
  endtask
  task automatic set_rst_n(input logic v);
    @(posedge clock);
    reset_n <= v;
  endtask
  // one command for one cycle with a chosen cke, then back to nop
  task automatic issue(input sdpt_pkg::sdpt_cmd_t c, input logic [2:0] b, input logic k);
    @(posedge clock);
    cmd <= c;
    cmd_bank <= b;
    cke <= k;
    @(posedge clock);
    cmd <= NOP;
    cke <= 1'b1;
  endtask
endmodule

// ===== tb/sdpt_power_down_and_termination_bench.sv
/*
  self-checking bench for sdpt_ctrl with the controller model.
  assumes a 50 mhz clock; expected values come from a small model here.
*/
module sdpt_power_down_and_termination_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // stimulus, all set at time zero
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] op_busy_cyc = 8'h00;
  logic [15:0] mr0 = 16'h0000;
  logic [15:0] mr1 = 16'h0000;
  logic [15:0] mr2 = 16'h0000;
  logic [4:0] cwl = 5'h05;
  logic [4:0] al = 5'h00;
  logic dll_locked = 1'b1;
  logic self_refresh = 1'b0;
  logic dq_driving = 1'b0;
  logic cke, odt, reset_n;
  logic [2:0] cmd_bank;
  sdpt_pkg::sdpt_cmd_t cmd;
  // observed
  sdpt_pkg::sdpt_state_t pd_state;
  logic in_buf_en, cmd_rx_en, dll_on, sync_odt;
  sdpt_pkg::sdpt_term_t term;
  // model state and counters
  int err_total = 0;
  int n_tests = 0;
  int lat;
  int banks;
  always #10 clock = ~clock;
  // the row timer counts itself down, like in-flight work would
  always @(posedge clock) if (op_busy_cyc != 8'h00) op_busy_cyc <= op_busy_cyc - 8'h01;
  sdpt_host ctl (.clock, .cke, .odt, .reset_n, .cmd, .cmd_bank);
  sdpt_ctrl dut (.clock, .sys_rst, .cke, .odt, .reset_n, .cmd, .cmd_bank, .op_busy_cyc, .mr0, .mr1, .mr2,
    .cwl, .al, .dll_locked, .self_refresh, .dq_driving, .pd_state, .in_buf_en, .cmd_rx_en, .dll_on,
    .sync_odt, .term);
  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // settle just after an edge before looking
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // entry with work still running for b cycles, b from 2 up
  task automatic enter(input int b);
    logic e;
    @(posedge clock);
    op_busy_cyc <= 8'(b);
    ctl.set_cke(1'b0);
    tick(1);
    chk(5'({in_buf_en, cmd_rx_en}), 5'h01);
    tick(b - 2);
    chk(5'(pd_state), 5'(sdpt_pkg::SDPT_ST_SETTLE));
    tick(1);
    e = (banks != 0) || mr0[12];
    // the type depends on open banks only; the exit bit only decides the dll
    chk(5'(pd_state), (banks != 0) ? 5'(sdpt_pkg::SDPT_ST_APD) : 5'(sdpt_pkg::SDPT_ST_PPD));
    chk(5'({cmd_rx_en, dll_on, sync_odt}), 5'({1'b0, e, e}));
  endtask
  // exit, then keep cke high past the minimum pulse and exit latency
  task automatic leave();
    // stays are a few cycles, far inside the refresh limit
    ctl.set_cke(1'b1);
    tick(1);
    chk(5'({pd_state, in_buf_en}), 5'({sdpt_pkg::SDPT_ST_ON, 1'b1}));
    tick(3);
  endtask
  // odt edge, term must follow exactly lat edges after sampling
  task automatic odt_step(input logic v, input logic en);
    ctl.set_odt(v);
    for (int k = 0; k <= lat; k++) begin
      tick(1);
      chk(5'(term.on), 5'(en && (k == lat ? v : !v)));
    end
    tick(4);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog far beyond the few hundred cycles the tests need
  initial begin
    #400000;
    err_total++;
    conclude();
  end
  initial begin
    void'($urandom(32'hd3ec));
    repeat (16) @(posedge clock);
    #1;
    chk(5'({term.on, in_buf_en, cmd_rx_en}), 5'h00);
    @(posedge clock);
    sys_rst <= 1'b0;
    tick(1);
    chk(5'(pd_state), 5'(sdpt_pkg::SDPT_ST_ON));
    $display("test reset done");
    // every mix of open bank and exit mode bit
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      mr0 <= {3'h0, i[1], 12'h000};
      banks = i[0];
      if (i[0]) ctl.issue(6'h10, 3'(i + 2), 1'b1);
      enter(2 + $urandom_range(3));
      leave();
      if (i[0]) ctl.issue((i == 1) ? 6'h08 : 6'h04, 3'(i + 2), 1'b1);
      banks = 0;
    end
    // reset in power-down, open banks forgotten
    ctl.issue(6'h10, 3'h1, 1'b1);
    banks = 1;
    enter(3);
    ctl.set_rst_n(1'b0);
    tick(1);
    chk(5'(pd_state), 5'(sdpt_pkg::SDPT_ST_RST));
    ctl.set_cke(1'b1);
    ctl.set_rst_n(1'b1);
    tick(1);
    banks = 0;
    enter(2);
    leave();
    // cke low with a write is no entry
    ctl.issue(6'h02, 3'h0, 1'b0);
    tick(2);
    chk(5'(pd_state), 5'(sdpt_pkg::SDPT_ST_ON));
    $display("test powerdown done");
    // nominal on, write-only on, all off
    for (int j = 0; j < 3; j++) begin
      @(posedge clock);
      cwl <= 5'(5 + $urandom_range(5));
      al <= 5'($urandom_range(3));
      mr1 <= (j == 0) ? 16'h0244 : 16'h0000;
      mr2 <= (j == 1) ? 16'h0600 : 16'h0000;
      tick(1);
      lat = cwl + al - 2;
      tick(lat);
      if (j == 0) chk(5'({term.nom, term.wrval}), 5'h1c);
      odt_step(1'b1, j < 2);
      if (j == 0) begin
        @(posedge clock);
        dq_driving <= 1'b1;
        tick(1);
        chk(5'(term.on), 5'h00);
        @(posedge clock);
        dq_driving <= 1'b0;
        tick(1);
        chk(5'(term.on), 5'h01);
        @(posedge clock);
        self_refresh <= 1'b1;
        ctl.issue(6'h20, 3'h0, 1'b0);
        tick(1);
        chk(5'({pd_state, term.on}), 5'({sdpt_pkg::SDPT_ST_ON, 1'b0}));
        @(posedge clock);
        self_refresh <= 1'b0;
      end
      odt_step(1'b0, j < 2);
      // unlocked dll: termination follows the pin one edge later
      if (j == 1) begin
        @(posedge clock);
        dll_locked <= 1'b0;
        ctl.set_odt(1'b1);
        tick(1);
        chk(5'({sync_odt, term.on}), 5'h01);
        tick(3);
        ctl.set_odt(1'b0);
        tick(1);
        chk(5'(term.on), 5'h00);
        @(posedge clock);
        dll_locked <= 1'b1;
      end
    end
    $display("test termination done");
    conclude();
  end
endmodule
